/* File: hdl/ldsc_pkg.sv */
// Functional notes
// [R1] Bit 13 forwards I/O 4Eh/4Fh
// [R2] Bit 12 forwards I/O 2Eh/2Fh
// [R3] Bit 11 forwards I/O 62h/66h
// [R4] Bit 10 forwards I/O 60h/64h
// [R5] Bit 9 forwards I/O 208h-20Fh
// [R6] Bit 8 forwards I/O 200h-207h
// [R7] Bit 7 forwards I/O 388h-38Bh
// [R8] Bits 6:4 forward selected audio ranges
// [R9] Bits 3/2 forward floppy/parallel ranges
// [R10] Bits 1/0 forward serial B/A ranges
// [R11] Top select field reads fixed zero
// [R12] Low select fields give 512K pair IDs
// [R13] Second window: base 15:4, 16 bytes, I/O
// [R14] Window enable bit 0 forwards hits
// [R15] High select fields give 1M pair IDs
// [R16] Bits 3:0 enable 1M pairs, reset 0Fh
// [R17] Subtractive claim unless positive decode set
// [R18] Bit 15 disables enhanced USB host
// [R19] Bits 9/8 disable universal USB hosts
// [R20] Software disables highest function first
// [R21] Software leaves disabled function features off
// [R22] Disabled function config space not decoded
// [R23] Forwarded firmware cycle carries window ID
package ldsc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0]  OFF_LPC_IO_DECODE_ENABLES       = 8'he6;
    localparam logic [7:0]  OFF_FIRMWARE_ID_SELECT_LOW      = 8'he8;
    localparam logic [7:0]  OFF_GENERIC_IO_WINDOW_TWO       = 8'hec;
    localparam logic [7:0]  OFF_FIRMWARE_ID_SELECT_HIGH     = 8'hee;
    localparam logic [7:0]  OFF_FIRMWARE_DECODE_ENABLE_TWO  = 8'hf0;
    localparam logic [7:0]  OFF_FUNCTION_DISABLE            = 8'hf2;

    localparam logic [15:0] RST_LPC_IO_DECODE_ENABLES       = 16'h0000;
    localparam logic [31:0] RST_FIRMWARE_ID_SELECT_LOW      = 32'h0011_2233;
    localparam logic [15:0] RST_GENERIC_IO_WINDOW_TWO       = 16'h0000;
    localparam logic [15:0] RST_FIRMWARE_ID_SELECT_HIGH     = 16'h4567;
    localparam logic [7:0]  RST_FIRMWARE_DECODE_ENABLE_TWO  = 8'h0f;
    localparam logic [15:0] RST_FUNCTION_DISABLE            = 16'h0080;

    // Writable bits; everything else keeps its reset value
    localparam logic [15:0] WMASK_LPC_IO_DECODE_ENABLES     = 16'h3fff;
    localparam logic [31:0] WMASK_FIRMWARE_ID_SELECT_LOW    = 32'h0fff_ffff;
    localparam logic [15:0] WMASK_GENERIC_IO_WINDOW_TWO     = 16'hfff1;
    localparam logic [15:0] WMASK_FIRMWARE_ID_SELECT_HIGH   = 16'hffff;
    localparam logic [7:0]  WMASK_FIRMWARE_DECODE_ENABLE_TWO = 8'h0f;
    localparam logic [15:0] WMASK_FUNCTION_DISABLE          = 16'h8300;

    ////////////////////////////////////////////////////////////////////////////
    localparam int BIT_CONFIG_PORT_B   = 13;
    localparam int BIT_CONFIG_PORT_A   = 12;
    localparam int BIT_EMBEDDED_CTRL   = 11;
    localparam int BIT_KEYBOARD_CTRL   = 10;
    localparam int BIT_GAME_PORT_HIGH  = 9;
    localparam int BIT_GAME_PORT_LOW   = 8;
    localparam int BIT_FM_SYNTH        = 7;
    localparam int BIT_AUDIO_SYSTEM    = 6;
    localparam int BIT_MUSIC_PORT      = 5;
    localparam int BIT_LEGACY_AUDIO    = 4;
    localparam int BIT_FLOPPY          = 3;
    localparam int BIT_PARALLEL_PORT   = 2;
    localparam int BIT_SERIAL_B        = 1;
    localparam int BIT_SERIAL_A        = 0;
    localparam int BIT_GEN_WINDOW_EN   = 0;
    localparam int BIT_USB_ENHANCED    = 15;
    localparam int BIT_USB_UNIVERSAL2  = 9;
    localparam int BIT_USB_UNIVERSAL1  = 8;
    localparam int GEN_WINDOW_BASE_LSB = 4;
    localparam int NUM_IO_SPANS        = 19;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic [31:0] addr;
    } ldsc_cycle_type;

    typedef struct packed {
        logic       valid;
        logic       to_lpc;
        logic       fw_cycle;
        logic [3:0] fw_id;
        logic       positive;
    } ldsc_route_type;

    typedef struct packed {
        logic [2:0] serial_a;
        logic [2:0] serial_b;
        logic       floppy;
        logic [1:0] parallel;
        logic [1:0] audio_system;
        logic       music;
        logic [1:0] legacy_audio;
    } ldsc_range_sel_type;

endpackage

/* File: hdl/ldsc_span_match.sv */
`timescale 1ns/1ps
`default_nettype none
module ldsc_span_match #(
    parameter int AW = 16
) (
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [AW-1:0] i_lo,
    input  wire logic [AW-1:0] i_hi,
    input  wire logic          i_en,
    output logic               o_hit
);
    // Inclusive bounds; an empty span uses lo above hi
    assign o_hit = i_en && (i_addr >= i_lo) && (i_addr <= i_hi);
endmodule
`default_nettype wire

/* File: hdl/ldsc_fw_window.sv */
`timescale 1ns/1ps
`default_nettype none
module ldsc_fw_window (
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_sel_low,
    input  wire logic [15:0] i_sel_high,
    input  wire logic [7:0]  i_en_low,
    input  wire logic [3:0]  i_en_high,
    output logic             o_hit,
    output logic [3:0]       o_id
);
    logic [2:0] idx_low;
    logic [1:0] idx_high;
    logic       in_low;
    logic       in_high;
    logic       in_legacy;

    // 512K pairs mirror at FF8x and FFCx; 1M pairs at FF0x and FF4x
    assign in_low    = (i_addr[31:23] == 9'h1ff);
    assign in_high   = (i_addr[31:23] == 9'h1fe);
    assign in_legacy = (i_addr[31:17] == 15'h0007);
    assign idx_low   = in_legacy ? 3'h7 : i_addr[21:19];
    assign idx_high  = i_addr[21:20];

    always_comb begin
        o_hit = 1'b0;
        o_id  = 4'h0;
        if (in_low || in_legacy) begin
            o_hit = i_en_low[idx_low]; // [R12]
            o_id  = i_sel_low[{idx_low, 2'b00} +: 4]; // [R23]
        end else if (in_high) begin
            o_hit = i_en_high[idx_high]; // [R16]
            o_id  = i_sel_high[{idx_high, 2'b00} +: 4]; // [R15] [R23]
        end
    end
endmodule
`default_nettype wire

/* File: hdl/ldsc_decode_config.sv */
`timescale 1ns/1ps
`default_nettype none
module ldsc_decode_config (
    input  wire logic                         i_ref_clk,
    input  wire logic                         i_sys_rst,
    // Configuration space access, dword addressed with byte enables
    input  wire logic                         i_cfg_wr,
    input  wire logic                         i_cfg_rd,
    input  wire logic [7:0]                   i_cfg_addr,
    input  wire logic [3:0]                   i_cfg_byte_en,
    input  wire logic [31:0]                  i_cfg_wdata,
    output logic [31:0]                       o_cfg_rdata,
    output logic                              o_cfg_rd_ack,
    // Settings held by neighbouring registers
    input  wire ldsc_pkg::ldsc_range_sel_type i_range_sel,
    input  wire logic [7:0]                   i_fw_decode_en_one,
    input  wire logic                         i_positive_decode_en,
    // Host cycle to classify
    input  wire ldsc_pkg::ldsc_cycle_type     i_cycle,
    output ldsc_pkg::ldsc_route_type          o_route,
    // Function hiding
    output logic                              o_usb_enhanced_host_off,
    output logic                              o_usb_universal_host2_off,
    output logic                              o_usb_universal_host1_off
);

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] lpc_io_decode_enables_reg;
    logic [31:0] firmware_id_select_low_reg;
    logic [15:0] generic_io_window_two_reg;
    logic [15:0] firmware_id_select_high_reg;
    logic [7:0]  firmware_decode_enable_two_reg;
    logic [15:0] function_disable_reg;
    logic [31:0] cfg_rdata_reg;
    logic        cfg_rd_ack_reg;
    ldsc_pkg::ldsc_route_type route_reg;
    ldsc_pkg::ldsc_route_type route_next;
    logic        usb_off_reg [3];

    logic [31:0] wr_bits;
    logic [31:0] wr_mask;
    logic [31:0] rd_word;

    ////////////////////////////////////////////////////////////////////////////
    // Byte-lane helpers: registers sit at their printed byte offsets

    function automatic logic [7:0] dword_of(input logic [7:0] off);
        dword_of = {off[7:2], 2'b00};
    endfunction

    function automatic logic [4:0] lane_shift(input logic [7:0] off);
        lane_shift = {off[1:0], 3'b000};
    endfunction

    assign wr_bits = i_cfg_wdata;
    assign wr_mask = {{8{i_cfg_byte_en[3]}}, {8{i_cfg_byte_en[2]}},
                      {8{i_cfg_byte_en[1]}}, {8{i_cfg_byte_en[0]}}};

    function automatic logic [31:0] merge32(input logic [31:0] cur,
                                            input logic [31:0] wmask);
        merge32 = (cur & ~(wmask & wr_mask)) | (wr_bits & wmask & wr_mask);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] cur,
                                            input logic [15:0] wmask,
                                            input logic [7:0]  off);
        logic [31:0] sh;
        sh = merge32({16'h0000, cur} << lane_shift(off),
                     {16'h0000, wmask} << lane_shift(off));
        merge16 = sh[lane_shift(off) +: 16];
    endfunction

    function automatic logic [7:0] merge8(input logic [7:0] cur,
                                          input logic [7:0] wmask,
                                          input logic [7:0] off);
        logic [31:0] sh;
        sh = merge32({24'h000000, cur} << lane_shift(off),
                     {24'h000000, wmask} << lane_shift(off));
        merge8 = sh[lane_shift(off) +: 8];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lpc_io_decode_enables_reg <= ldsc_pkg::RST_LPC_IO_DECODE_ENABLES;
        end else if (i_cfg_wr && i_cfg_addr == dword_of(ldsc_pkg::OFF_LPC_IO_DECODE_ENABLES)) begin
            lpc_io_decode_enables_reg <= merge16(lpc_io_decode_enables_reg,
                ldsc_pkg::WMASK_LPC_IO_DECODE_ENABLES, ldsc_pkg::OFF_LPC_IO_DECODE_ENABLES);
        end
    end

    // Top nibble is outside the write mask, so it stays zero
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            firmware_id_select_low_reg <= ldsc_pkg::RST_FIRMWARE_ID_SELECT_LOW; // [R12]
        end else if (i_cfg_wr && i_cfg_addr == dword_of(ldsc_pkg::OFF_FIRMWARE_ID_SELECT_LOW)) begin
            firmware_id_select_low_reg <= merge32(firmware_id_select_low_reg,
                ldsc_pkg::WMASK_FIRMWARE_ID_SELECT_LOW); // [R11]
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            generic_io_window_two_reg <= ldsc_pkg::RST_GENERIC_IO_WINDOW_TWO;
        end else if (i_cfg_wr && i_cfg_addr == dword_of(ldsc_pkg::OFF_GENERIC_IO_WINDOW_TWO)) begin
            generic_io_window_two_reg <= merge16(generic_io_window_two_reg,
                ldsc_pkg::WMASK_GENERIC_IO_WINDOW_TWO, ldsc_pkg::OFF_GENERIC_IO_WINDOW_TWO); // [R13]
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            firmware_id_select_high_reg <= ldsc_pkg::RST_FIRMWARE_ID_SELECT_HIGH; // [R15]
        end else if (i_cfg_wr && i_cfg_addr == dword_of(ldsc_pkg::OFF_FIRMWARE_ID_SELECT_HIGH)) begin
            firmware_id_select_high_reg <= merge16(firmware_id_select_high_reg,
                ldsc_pkg::WMASK_FIRMWARE_ID_SELECT_HIGH, ldsc_pkg::OFF_FIRMWARE_ID_SELECT_HIGH);
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            firmware_decode_enable_two_reg <= ldsc_pkg::RST_FIRMWARE_DECODE_ENABLE_TWO; // [R16]
        end else if (i_cfg_wr && i_cfg_addr == dword_of(ldsc_pkg::OFF_FIRMWARE_DECODE_ENABLE_TWO)) begin
            firmware_decode_enable_two_reg <= merge8(firmware_decode_enable_two_reg,
                ldsc_pkg::WMASK_FIRMWARE_DECODE_ENABLE_TWO,
                ldsc_pkg::OFF_FIRMWARE_DECODE_ENABLE_TWO); // [R16]
        end
    end

    // Only the USB disables live here; bit 7 keeps its reset one
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            function_disable_reg <= ldsc_pkg::RST_FUNCTION_DISABLE; // [R18]
        end else if (i_cfg_wr && i_cfg_addr == dword_of(ldsc_pkg::OFF_FUNCTION_DISABLE)) begin
            function_disable_reg <= merge16(function_disable_reg,
                ldsc_pkg::WMASK_FUNCTION_DISABLE, ldsc_pkg::OFF_FUNCTION_DISABLE); // [R18] [R19]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads, one cycle after the strobe

    always_comb begin
        rd_word = 32'h0000_0000;
        case (i_cfg_addr)
            dword_of(ldsc_pkg::OFF_LPC_IO_DECODE_ENABLES): begin
                rd_word = {16'h0000, lpc_io_decode_enables_reg}
                          << lane_shift(ldsc_pkg::OFF_LPC_IO_DECODE_ENABLES);
            end
            dword_of(ldsc_pkg::OFF_FIRMWARE_ID_SELECT_LOW): begin
                rd_word = firmware_id_select_low_reg;
            end
            dword_of(ldsc_pkg::OFF_GENERIC_IO_WINDOW_TWO): begin
                rd_word = ({16'h0000, generic_io_window_two_reg}
                           << lane_shift(ldsc_pkg::OFF_GENERIC_IO_WINDOW_TWO))
                        | ({16'h0000, firmware_id_select_high_reg}
                           << lane_shift(ldsc_pkg::OFF_FIRMWARE_ID_SELECT_HIGH));
            end
            dword_of(ldsc_pkg::OFF_FIRMWARE_DECODE_ENABLE_TWO): begin
                rd_word = ({24'h000000, firmware_decode_enable_two_reg}
                           << lane_shift(ldsc_pkg::OFF_FIRMWARE_DECODE_ENABLE_TWO))
                        | ({16'h0000, function_disable_reg}
                           << lane_shift(ldsc_pkg::OFF_FUNCTION_DISABLE));
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cfg_rdata_reg  <= 32'h0000_0000;
            cfg_rd_ack_reg <= 1'b0;
        end else begin
            cfg_rd_ack_reg <= i_cfg_rd;
            // Unselected byte lanes read zero
            cfg_rdata_reg  <= i_cfg_rd ? (rd_word & wr_mask) : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // I/O span table; legacy tables mirror the range-select registers

    logic [15:0] span_lo [ldsc_pkg::NUM_IO_SPANS];
    logic [15:0] span_hi [ldsc_pkg::NUM_IO_SPANS];
    logic        span_en [ldsc_pkg::NUM_IO_SPANS];
    logic [ldsc_pkg::NUM_IO_SPANS-1:0] span_hit;

    function automatic logic [15:0] serial_base(input logic [2:0] sel);
        case (sel)
            3'h0:    serial_base = 16'h03f8;
            3'h1:    serial_base = 16'h02f8;
            3'h2:    serial_base = 16'h0220;
            3'h3:    serial_base = 16'h0228;
            3'h4:    serial_base = 16'h0238;
            3'h5:    serial_base = 16'h02e8;
            3'h6:    serial_base = 16'h0338;
            default: serial_base = 16'h03e8;
        endcase
    endfunction

    function automatic logic [15:0] audio_system_base(input logic [1:0] sel);
        case (sel)
            2'h0:    audio_system_base = 16'h0530;
            2'h1:    audio_system_base = 16'h0604;
            2'h2:    audio_system_base = 16'h0e80;
            default: audio_system_base = 16'h0f40;
        endcase
    endfunction

    function automatic logic [15:0] parallel_base(input logic [1:0] sel);
        case (sel)
            2'h0:    parallel_base = 16'h0378;
            2'h1:    parallel_base = 16'h0278;
            default: parallel_base = 16'h03bc;
        endcase
    endfunction

    logic [15:0] io_en;
    logic [15:0] lpt_lo;
    logic [15:0] lpt_span;
    logic        lpt_ok;
    logic [15:0] fdd_base;
    logic [15:0] gen_base;

    assign io_en    = lpc_io_decode_enables_reg;
    assign lpt_lo   = parallel_base(i_range_sel.parallel);
    assign lpt_span = (i_range_sel.parallel == 2'h2) ? 16'h0002 : 16'h0007;
    assign lpt_ok   = (i_range_sel.parallel != 2'h3);
    assign fdd_base = i_range_sel.floppy ? 16'h0370 : 16'h03f0;
    // Window is 16 bytes, matching the 16-byte alignment of the base field at bits 15:4
    assign gen_base = {generic_io_window_two_reg[15:ldsc_pkg::GEN_WINDOW_BASE_LSB], 4'h0};

    always_comb begin
        span_lo[0]  = 16'h004e; span_hi[0]  = 16'h004f; span_en[0]  = io_en[ldsc_pkg::BIT_CONFIG_PORT_B]; // [R1]
        span_lo[1]  = 16'h002e; span_hi[1]  = 16'h002f; span_en[1]  = io_en[ldsc_pkg::BIT_CONFIG_PORT_A]; // [R2]
        span_lo[2]  = 16'h0062; span_hi[2]  = 16'h0062; span_en[2]  = io_en[ldsc_pkg::BIT_EMBEDDED_CTRL]; // [R3]
        span_lo[3]  = 16'h0066; span_hi[3]  = 16'h0066; span_en[3]  = io_en[ldsc_pkg::BIT_EMBEDDED_CTRL]; // [R3]
        span_lo[4]  = 16'h0060; span_hi[4]  = 16'h0060; span_en[4]  = io_en[ldsc_pkg::BIT_KEYBOARD_CTRL]; // [R4]
        span_lo[5]  = 16'h0064; span_hi[5]  = 16'h0064; span_en[5]  = io_en[ldsc_pkg::BIT_KEYBOARD_CTRL]; // [R4]
        span_lo[6]  = 16'h0208; span_hi[6]  = 16'h020f; span_en[6]  = io_en[ldsc_pkg::BIT_GAME_PORT_HIGH]; // [R5]
        span_lo[7]  = 16'h0200; span_hi[7]  = 16'h0207; span_en[7]  = io_en[ldsc_pkg::BIT_GAME_PORT_LOW]; // [R6]
        span_lo[8]  = 16'h0388; span_hi[8]  = 16'h038b; span_en[8]  = io_en[ldsc_pkg::BIT_FM_SYNTH]; // [R7]
        span_lo[9]  = audio_system_base(i_range_sel.audio_system);
        span_hi[9]  = span_lo[9] + 16'h0007;
        span_en[9]  = io_en[ldsc_pkg::BIT_AUDIO_SYSTEM]; // [R8]
        span_lo[10] = i_range_sel.music ? 16'h0300 : 16'h0330;
        span_hi[10] = span_lo[10] + 16'h0001;
        span_en[10] = io_en[ldsc_pkg::BIT_MUSIC_PORT]; // [R8]
        span_lo[11] = 16'h0220 + {10'h000, i_range_sel.legacy_audio, 4'h0} + {10'h000, i_range_sel.legacy_audio, 4'h0};
        span_hi[11] = span_lo[11] + 16'h0013;
        span_en[11] = io_en[ldsc_pkg::BIT_LEGACY_AUDIO]; // [R8]
        // Floppy range skips offset 6, which belongs to the disk drive
        span_lo[12] = fdd_base;
        span_hi[12] = fdd_base + 16'h0005;
        span_en[12] = io_en[ldsc_pkg::BIT_FLOPPY]; // [R9]
        span_lo[13] = fdd_base + 16'h0007;
        span_hi[13] = fdd_base + 16'h0007;
        span_en[13] = io_en[ldsc_pkg::BIT_FLOPPY]; // [R9]
        span_lo[14] = lpt_lo;
        span_hi[14] = lpt_lo + lpt_span;
        span_en[14] = io_en[ldsc_pkg::BIT_PARALLEL_PORT] && lpt_ok; // [R9]
        span_lo[15] = lpt_lo + 16'h0400;
        span_hi[15] = lpt_lo + 16'h0400 + lpt_span;
        span_en[15] = io_en[ldsc_pkg::BIT_PARALLEL_PORT] && lpt_ok; // [R9]
        span_lo[16] = serial_base(i_range_sel.serial_b);
        span_hi[16] = span_lo[16] + 16'h0007;
        span_en[16] = io_en[ldsc_pkg::BIT_SERIAL_B]; // [R10]
        span_lo[17] = serial_base(i_range_sel.serial_a);
        span_hi[17] = span_lo[17] + 16'h0007;
        span_en[17] = io_en[ldsc_pkg::BIT_SERIAL_A]; // [R10]
        span_lo[18] = gen_base;
        span_hi[18] = gen_base + 16'h000f; // [R13]
        span_en[18] = generic_io_window_two_reg[ldsc_pkg::BIT_GEN_WINDOW_EN]; // [R14]
    end

    genvar g;
    generate
        for (g = 0; g < ldsc_pkg::NUM_IO_SPANS; g++) begin : g_span
            ldsc_span_match #(
                .AW (16)
            ) u_span (
                .i_addr (i_cycle.addr[15:0]),
                .i_lo   (span_lo[g]),
                .i_hi   (span_hi[g]),
                .i_en   (span_en[g]),
                .o_hit  (span_hit[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Firmware memory windows

    logic       fw_hit;
    logic [3:0] fw_id;

    // Top enable bit is read-only one in the neighbouring register
    ldsc_fw_window u_fw_window (
        .i_addr     (i_cycle.addr),
        .i_sel_low  (firmware_id_select_low_reg),
        .i_sel_high (firmware_id_select_high_reg),
        .i_en_low   (i_fw_decode_en_one),
        .i_en_high  (firmware_decode_enable_two_reg[3:0]),
        .o_hit      (fw_hit),
        .o_id       (fw_id)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Route decision, registered one cycle after the cycle is presented

    always_comb begin
        route_next          = '0;
        route_next.valid    = i_cycle.valid;
        // I/O decode only covers the low 64K of I/O space
        route_next.to_lpc   = i_cycle.valid && i_cycle.is_io
                              && (i_cycle.addr[31:16] == 16'h0000) && (|span_hit); // [R13]
        route_next.fw_cycle = i_cycle.valid && !i_cycle.is_io && fw_hit;
        route_next.fw_id    = route_next.fw_cycle ? fw_id : 4'h0; // [R23]
        route_next.positive = route_next.fw_cycle && i_positive_decode_en; // [R17]
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            route_reg <= '0;
        end else begin
            route_reg <= route_next;
        end
    end

    // Disabled functions drop out of configuration decode
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            usb_off_reg <= '{default: 1'b0};
        end else begin
            usb_off_reg[0] <= function_disable_reg[ldsc_pkg::BIT_USB_ENHANCED]; // [R22]
            usb_off_reg[1] <= function_disable_reg[ldsc_pkg::BIT_USB_UNIVERSAL2]; // [R22]
            usb_off_reg[2] <= function_disable_reg[ldsc_pkg::BIT_USB_UNIVERSAL1]; // [R22]
        end
    end

    assign o_cfg_rdata               = cfg_rdata_reg;
    assign o_cfg_rd_ack              = cfg_rd_ack_reg;
    assign o_route                   = route_reg;
    assign o_usb_enhanced_host_off   = usb_off_reg[0];
    assign o_usb_universal_host2_off = usb_off_reg[1];
    assign o_usb_universal_host1_off = usb_off_reg[2];

endmodule
`default_nettype wire

/* File: sim/ldsc_decode_config_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ldsc_decode_config_checker (
    input wire logic                     i_ref_clk,
    input wire logic                     i_sys_rst,
    input wire logic                     i_cfg_rd,
    input wire logic [7:0]               i_cfg_addr,
    input wire logic                     i_positive_decode_en,
    input wire ldsc_pkg::ldsc_cycle_type i_cycle,
    input wire ldsc_pkg::ldsc_route_type o_route,
    input wire logic                     o_cfg_rd_ack,
    input wire logic [31:0]              o_cfg_rdata
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    sequence rd_at(logic [7:0] a);
        i_cfg_rd && i_cfg_addr == a;
    endsequence
    AST_RD_ACK: assert property (i_cfg_rd |=> o_cfg_rd_ack)
        else $error("read ack missing");
    AST_TOP_ID: assert property (rd_at(8'he8) |=> o_cfg_rdata[31:28] == 4'h0)
        else $error("top id field not zero");
    AST_WIN_RSVD: assert property (rd_at(8'hec) |=> o_cfg_rdata[3:1] == 3'h0)
        else $error("window reserved bits set");
    AST_DEC_RSVD: assert property (rd_at(8'hf0) |=> o_cfg_rdata[15:4] == 12'h0)
        else $error("decode reserved bits set");
    AST_HIGH_IO: assert property (i_cycle.valid && i_cycle.is_io &&
        i_cycle.addr[31:16] != 16'h0 |=> !o_route.to_lpc) else $error("high io forwarded");
    AST_FW_MEM: assert property (o_route.fw_cycle |-> $past(i_cycle.is_io) == 1'b0)
        else $error("firmware cycle from io");
    AST_NO_ID: assert property (!o_route.fw_cycle |-> o_route.fw_id == 4'h0)
        else $error("id without firmware hit");
    AST_POS: assert property (o_route.fw_cycle |->
        o_route.positive == $past(i_positive_decode_en)) else $error("claim mode wrong");
endmodule
`default_nettype wire

/* File: sim/ldsc_lpc_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module ldsc_lpc_peer (
    input  wire logic                     i_ref_clk,
    input  wire ldsc_pkg::ldsc_route_type i_route,
    output logic [3:0]                    o_last_id
);
    // Device records the id of every firmware cycle it sees
    always_ff @(posedge i_ref_clk) begin
        if (i_route.fw_cycle) begin
            o_last_id <= i_route.fw_id;
        end
    end
endmodule
`default_nettype wire

/* File: sim/test_lpc_decode_select_config.sv */
`timescale 1ns/1ps
`default_nettype none
module test_lpc_decode_select_config;
    logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, i_cfg_wr = 1'b0, i_cfg_rd = 1'b0;
    logic i_positive_decode_en = 1'b0, o_cfg_rd_ack;
    logic o_usb_enhanced_host_off, o_usb_universal_host2_off, o_usb_universal_host1_off;
    logic [7:0] i_cfg_addr = 8'h0, i_fw_decode_en_one = 8'hff;
    logic [3:0] i_cfg_byte_en = 4'h0, peer_id;
    logic [31:0] i_cfg_wdata = 32'h0, o_cfg_rdata;
    ldsc_pkg::ldsc_range_sel_type i_range_sel = '0;
    ldsc_pkg::ldsc_cycle_type i_cycle = '0;
    ldsc_pkg::ldsc_route_type o_route;
    int err_total = 0, n_tests = 0;
    // Rows: is_io, address, then forward flag or firmware flag with id
    localparam logic [37:0] ROWS [16] = '{{1'b1, 32'h4e, 5'h10}, {1'b1, 32'h2f, 5'h10},
        {1'b1, 32'h66, 5'h10}, {1'b1, 32'h64, 5'h10}, {1'b1, 32'h20f, 5'h10},
        {1'b1, 32'h200, 5'h10}, {1'b1, 32'h38b, 5'h10}, {1'b1, 32'h220, 5'h10},
        {1'b1, 32'h3f8, 5'h10}, {1'b1, 32'h3f7, 5'h10}, {1'b1, 32'h1004e, 5'h00},
        {1'b1, 32'h4d, 5'h00}, {1'b0, 32'hffc00000, 5'h13}, {1'b0, 32'h000e0000, 5'h10},
        {1'b0, 32'hfff80000, 5'h10}, {1'b0, 32'hff300000, 5'h14}};
    ldsc_decode_config uut (.i_ref_clk, .i_sys_rst, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr,
        .i_cfg_byte_en, .i_cfg_wdata, .o_cfg_rdata, .o_cfg_rd_ack, .i_range_sel,
        .i_fw_decode_en_one, .i_positive_decode_en, .i_cycle, .o_route,
        .o_usb_enhanced_host_off, .o_usb_universal_host2_off, .o_usb_universal_host1_off);
    ldsc_lpc_peer peer (.i_ref_clk, .i_route(o_route), .o_last_id(peer_id));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read checks ack too, since data only stands for that one cycle
    task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] d);
        @(negedge i_ref_clk);
        {i_cfg_wr, i_cfg_rd, i_cfg_addr, i_cfg_byte_en, i_cfg_wdata} = {w, !w, a, b, d};
        @(negedge i_ref_clk);
        {i_cfg_wr, i_cfg_rd} = 2'b00;
        if (!w) chk({o_cfg_rd_ack, o_cfg_rdata}, {1'b1, d});
    endtask
    task automatic cls(input logic [37:0] r);
        @(negedge i_ref_clk);
        i_cycle = {1'b1, r[37:5]};
        @(negedge i_ref_clk);
        i_cycle = '0;
        chk({o_route.valid, r[37] ? {o_route.to_lpc, 4'h0} : {o_route.fw_cycle,
            o_route.fw_id}}, {1'b1, r[4:0]});
    endtask
    task automatic complete_run;
        $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial forever #2 i_ref_clk = ~i_ref_clk;
    initial begin
        repeat (2000) @(posedge i_ref_clk);
        err_total++;
        complete_run;
    end
    initial begin
        repeat (10) @(posedge i_ref_clk);
        @(negedge i_ref_clk) i_sys_rst = 1'b0;
        cfg(0, 8'he8, 4'hf, 32'h00112233);
        cfg(0, 8'hec, 4'hf, 32'h45670000);
        cfg(0, 8'hf0, 4'hf, 32'h0080000f);
        chk({o_usb_enhanced_host_off, o_usb_universal_host2_off, o_usb_universal_host1_off}, 0);
        cfg(1, 8'he4, 4'hc, 32'hffff0000);
        cfg(0, 8'he4, 4'hf, 32'h3fff0000);
        for (int k = 0; k < 16; k++) begin
            i_positive_decode_en = k[0];
            cls(ROWS[k]);
        end
        cfg(1, 8'hf0, 4'h8, 32'h80000000);
        chk(peer_id, 4'h4);
        cfg(1, 8'hf0, 4'h8, 32'h82000000);
        cfg(1, 8'hf0, 4'h9, 32'h83000000);
        cfg(0, 8'hf0, 4'hf, 32'h83800000);
        chk({o_usb_enhanced_host_off, o_usb_universal_host2_off, o_usb_universal_host1_off}, 7);
        cls({1'b0, 32'hff000000, 5'h00});
        cfg(1, 8'he8, 4'hf, 32'hffffffff);
        cfg(0, 8'he8, 4'hf, 32'h0fffffff);
        cfg(1, 8'hec, 4'h3, 32'h0000030f);
        cfg(0, 8'hec, 4'hf, 32'h45670301);
        cls({1'b1, 32'h30a, 5'h10});
        cls({1'b1, 32'h310, 5'h00});
        cfg(1, 8'hf4, 4'hf, 32'hffffffff);
        cfg(0, 8'hf4, 4'hf, 32'h0);
        complete_run;
    end
endmodule
bind ldsc_decode_config ldsc_decode_config_checker chk (.i_ref_clk, .i_sys_rst, .i_cfg_rd,
    .i_cfg_addr, .i_positive_decode_en, .i_cycle, .o_route, .o_cfg_rd_ack, .o_cfg_rdata);
`default_nettype wire
